/* verilog/rbu_pkg.sv */
`default_nettype none

package rbu_pkg;

  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned BLOCK_BYTES = 32;
  localparam int unsigned BLOCK_LSB   = $clog2(BLOCK_BYTES);
  localparam int unsigned WORD_MASK_W = 2;
  localparam logic [3:0]  COND_RESET  = 4'h0;
  localparam logic [3:0]  COND_UNDEF  = 4'h0;
  localparam int unsigned COND_EQ_BIT = 1;

  typedef enum logic [1:0] {
    RBU_OP_LOAD_RESERVE,
    RBU_OP_STORE_COND,
    RBU_OP_BARRIER,
    RBU_OP_OTHER
  } rbu_op_t;

  typedef struct packed {
    logic              valid;
    rbu_op_t           op;
    logic              record_bit;
    logic [ADDR_W-1:0] addr;
  } rbu_req_t;

  typedef struct packed {
    logic       valid;
    logic       align_exc;
    logic       store_go;
    logic       cond_valid;
    logic [3:0] cond_field;
  } rbu_rsp_t;

endpackage : rbu_pkg

`default_nettype wire

/* verilog/rbu_resv_track.sv */
`timescale 1ns/10ps
`default_nettype none

module rbu_resv_track
#(
  parameter int unsigned ADDR_W    = 32,
  parameter int unsigned BLOCK_LSB = 5
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              set_in,
  input  wire logic              clear_in,
  input  wire logic              snoop_kill_in,
  input  wire logic [ADDR_W-1:0] set_addr_in,
  input  wire logic [ADDR_W-1:0] check_addr_in,
  output logic                   hit_out,
  output logic                   valid_out
);

  logic                        valid_reg;
  logic [ADDR_W-BLOCK_LSB-1:0] block_reg;

  // Whole-block tag compare
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      block_reg <= '0;
    end
    else if (set_in)
    begin
      block_reg <= set_addr_in[ADDR_W-1:BLOCK_LSB];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      valid_reg <= 1'b0;
    end
    else if (set_in)
    begin
      valid_reg <= 1'b1;
    end
    else if (clear_in || snoop_kill_in)
    begin
      valid_reg <= 1'b0;
    end
  end

  assign hit_out   = valid_reg && (block_reg == check_addr_in[ADDR_W-1:BLOCK_LSB]);
  assign valid_out = valid_reg;

endmodule : rbu_resv_track

`default_nettype wire

/* verilog/rbu_top.sv */
// Operation
// - Misaligned reserve-load or conditional-store address raises alignment exception.
// - Reservation covers a whole 32-byte block, not a single word.
// - Barrier may join earlier group; later dispatch blocked until barrier completes.
// - Prefetched instructions are kept when the barrier completes.
// - Barrier goes to load/store unit, which broadcasts it on bus.
// - Barrier or reserve-load with record bit set leaves condition field undefined.
// - Conditional store with record bit clear leaves condition field undefined.
`timescale 1ns/10ps
`default_nettype none

module rbu_top
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire rbu_pkg::rbu_req_t req_in,
  input  wire logic          barrier_done_in,
  input  wire logic          snoop_kill_in,
  output var rbu_pkg::rbu_rsp_t rsp_out,
  output logic               dispatch_block_out,
  output logic               lsu_barrier_out,
  output logic               ibuf_flush_out,
  output logic [3:0]         cond_field_zero_out
);

  typedef enum logic [1:0] {RBU_IDLE, RBU_WAIT} rbu_state_t;

  rbu_state_t        state_reg;
  rbu_pkg::rbu_rsp_t rsp_reg;
  logic [3:0]        cond_reg;
  logic              lsu_barrier_reg;
  logic              is_lr;
  logic              is_sc;
  logic              is_bar;
  logic              misalign;
  logic              resv_hit;
  logic              resv_set;
  logic              resv_clear;
  logic              req_ok;

  assign req_ok   = req_in.valid && (state_reg == RBU_IDLE);
  assign is_lr    = req_ok && (req_in.op == rbu_pkg::RBU_OP_LOAD_RESERVE);
  assign is_sc    = req_ok && (req_in.op == rbu_pkg::RBU_OP_STORE_COND);
  assign is_bar   = req_ok && (req_in.op == rbu_pkg::RBU_OP_BARRIER);
  assign misalign = |req_in.addr[rbu_pkg::WORD_MASK_W-1:0];

  assign resv_set   = is_lr && !misalign;
  assign resv_clear = is_sc && !misalign;

  rbu_resv_track
  #(
    .ADDR_W    (rbu_pkg::ADDR_W),
    .BLOCK_LSB (rbu_pkg::BLOCK_LSB)
  )
  u_resv
  (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .set_in        (resv_set),
    .clear_in      (resv_clear),
    .snoop_kill_in (snoop_kill_in),
    .set_addr_in   (req_in.addr),
    .check_addr_in (req_in.addr),
    .hit_out       (resv_hit),
    .valid_out     ()
  );

  // Barrier serialisation
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= RBU_IDLE;
    end
    else
    begin
      unique case (state_reg)
        RBU_IDLE:
        begin
          if (is_bar)
          begin
            state_reg <= RBU_WAIT;
          end
        end
        RBU_WAIT:
        begin
          if (barrier_done_in)
          begin
            state_reg <= RBU_IDLE;
          end
        end
        default:
        begin
          state_reg <= RBU_IDLE;
        end
      endcase
    end
  end

  // Combinational stall so the next group is held at once
  assign dispatch_block_out = is_bar || (state_reg == RBU_WAIT);
  // Prefetch buffer never purged here
  assign ibuf_flush_out = 1'b0;

  // One-cycle barrier request to the load/store unit
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lsu_barrier_reg <= 1'b0;
    end
    else
    begin
      lsu_barrier_reg <= is_bar;
    end
  end
  assign lsu_barrier_out = lsu_barrier_reg;

  // Response and condition field
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rsp_reg  <= '0;
      cond_reg <= rbu_pkg::COND_RESET;
    end
    else
    begin
      rsp_reg.valid      <= is_lr || is_sc || is_bar;
      rsp_reg.align_exc  <= (is_lr || is_sc) && misalign;
      rsp_reg.store_go   <= is_sc && !misalign && resv_hit;
      rsp_reg.cond_valid <= 1'b0;
      rsp_reg.cond_field <= cond_reg;
      if ((is_lr || is_bar) && req_in.record_bit)
      begin
        cond_reg           <= rbu_pkg::COND_UNDEF;
        rsp_reg.cond_valid <= 1'b1;
        rsp_reg.cond_field <= rbu_pkg::COND_UNDEF;
      end
      else if (is_sc && !misalign)
      begin
        if (req_in.record_bit)
        begin
          cond_reg <= {2'b00, resv_hit, 1'b0};
          rsp_reg.cond_field <= {2'b00, resv_hit, 1'b0};
        end
        else
        begin
          cond_reg <= rbu_pkg::COND_UNDEF;
          rsp_reg.cond_field <= rbu_pkg::COND_UNDEF;
        end
        rsp_reg.cond_valid <= 1'b1;
      end
    end
  end

  assign rsp_out             = rsp_reg;
  assign cond_field_zero_out = cond_reg;

  property p_misalign_exc;
    @(posedge clk_in) disable iff (rst_in)
      ((is_lr || is_sc) && misalign) |=> (rsp_out.align_exc && !rsp_out.store_go);
  endproperty
  a_misalign_exc: assert property (p_misalign_exc) else $error("missing alignment exception");

  property p_aligned_no_exc;
    @(posedge clk_in) disable iff (rst_in)
      ((is_lr || is_sc) && !misalign) |=> !rsp_out.align_exc;
  endproperty
  a_aligned_no_exc: assert property (p_aligned_no_exc) else $error("spurious alignment exception");

  property p_block_hit;
    @(posedge clk_in) disable iff (rst_in)
      (resv_set && !snoop_kill_in) ##1 (is_sc && !misalign && !snoop_kill_in &&
        (req_in.addr[31:5] == $past(req_in.addr[31:5]))) |=> rsp_out.store_go;
  endproperty
  a_block_hit: assert property (p_block_hit) else $error("block reservation missed");

  property p_bar_block;
    @(posedge clk_in) disable iff (rst_in)
      (dispatch_block_out && !barrier_done_in) |=> dispatch_block_out;
  endproperty
  a_bar_block: assert property (p_bar_block) else $error("dispatch not blocked");

  property p_no_flush;
    @(posedge clk_in) disable iff (rst_in)
      ($fell(state_reg == RBU_WAIT)) |-> !ibuf_flush_out;
  endproperty
  a_no_flush: assert property (p_no_flush) else $error("prefetch flushed");

  property p_lsu_bar;
    @(posedge clk_in) disable iff (rst_in)
      is_bar |=> (lsu_barrier_out ##1 !lsu_barrier_out);
  endproperty
  a_lsu_bar: assert property (p_lsu_bar) else $error("barrier not sent once");

  property p_sc_clears;
    @(posedge clk_in) disable iff (rst_in)
      (is_sc && !misalign) ##1 (is_sc && !misalign && !is_lr) |=> !rsp_out.store_go;
  endproperty
  a_sc_clears: assert property (p_sc_clears) else $error("reservation not cleared");

  property p_sc_report;
    @(posedge clk_in) disable iff (rst_in)
      (is_sc && !misalign && req_in.record_bit) |=>
        (rsp_out.cond_valid && (cond_field_zero_out[1] == rsp_out.store_go));
  endproperty
  a_sc_report: assert property (p_sc_report) else $error("bad store result");

  property p_undef_form;
    @(posedge clk_in) disable iff (rst_in)
      (((is_lr || is_bar) && req_in.record_bit) || (is_sc && !misalign && !req_in.record_bit))
        |=> rsp_out.cond_valid;
  endproperty
  a_undef_form: assert property (p_undef_form) else $error("undefined form not flagged");

  c_bar: cover property (@(posedge clk_in) disable iff (rst_in) is_bar ##[1:20] barrier_done_in);
  c_sc_ok: cover property (@(posedge clk_in) disable iff (rst_in) rsp_out.store_go);
  c_misal: cover property (@(posedge clk_in) disable iff (rst_in) rsp_out.align_exc);

endmodule : rbu_top

`default_nettype wire

/* dv/rbu_lsu_model.sv */
`timescale 1ns/10ps
`default_nettype none

module rbu_lsu_model
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic barrier_in,
  input  wire logic slow_in,
  output logic      done_out
);
  logic       busy_reg;
  logic [3:0] cnt_reg;

  // Bus ordering ack, prompt or slow
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_reg <= 1'b0;
      cnt_reg  <= 4'h0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (barrier_in)
      begin
        busy_reg <= 1'b1;
        cnt_reg  <= slow_in ? 4'h6 : 4'h1;
      end
      else if (busy_reg)
      begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule : rbu_lsu_model

`default_nettype wire

/* dv/rbu_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module rbu_top_tb;
  logic              clk_in, rst_in, snoop_kill_in, slow, done, blk, lsu, ibuf, resv_v;
  rbu_pkg::rbu_req_t req_in;
  rbu_pkg::rbu_rsp_t rsp_out;
  logic [3:0]        cfz;
  logic [31:0]       rnd;
  logic [26:0]       resv_tag;
  logic [7:0]        expq[$];
  logic [7:0]        e;
  int                mismatches, n_compared, cycles;

  rbu_top dut(.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .barrier_done_in(done),
    .snoop_kill_in(snoop_kill_in), .rsp_out(rsp_out), .dispatch_block_out(blk),
    .lsu_barrier_out(lsu), .ibuf_flush_out(ibuf), .cond_field_zero_out(cfz));
  rbu_lsu_model lsu_m(.clk_in(clk_in), .rst_in(rst_in), .barrier_in(lsu), .slow_in(slow),
    .done_out(done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp(input string nm, input logic [3:0] ex, input logic [3:0] got);
    n_compared++;
    if (got !== ex)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp

  task automatic print_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic kill;
    @(posedge clk_in);
    req_in.valid  <= 1'b0;
    snoop_kill_in <= 1'b1;
    resv_v = 1'b0;
    @(posedge clk_in);
    snoop_kill_in <= 1'b0;
  endtask : kill

  // Expectation: {cond care, cond valid, align, go, cond}
  task automatic issue(input logic [1:0] opc, input logic rb, input logic [31:0] a);
    logic mis;
    logic hit;
    mis = a[1:0] != 2'b00 && !opc[1];
    hit = resv_v && resv_tag == a[31:5];
    @(posedge clk_in);
    req_in <= '{1'b1, rbu_pkg::rbu_op_t'(opc), rb, a};
    if (opc == 2'd1)
    begin
      expq.push_back({!mis, !mis, mis, hit & !mis,
        rb & hit & !mis ? 4'h2 : rbu_pkg::COND_UNDEF});
      if (!mis)
        resv_v = 1'b0;
    end
    else if (opc != 2'd3)
    begin
      expq.push_back({rb & !mis, rb, mis, 1'b0, rbu_pkg::COND_UNDEF});
      if (opc == 2'd0 && !mis)
        {resv_v, resv_tag} = {1'b1, a[31:5]};
    end
    if (opc == 2'd2)
    begin
      #1 cmp("dispatch_block", 4'h1, {3'h0, blk});
      @(posedge clk_in);
      req_in <= '{1'b1, rbu_pkg::RBU_OP_STORE_COND, 1'b1, a};
      #1 cmp("lsu_barrier", 4'h1, {3'h0, lsu});
      @(posedge clk_in);
      req_in.valid <= 1'b0;
      #1 cmp("lsu_barrier", 4'h0, {3'h0, lsu});
      repeat (20)
      begin
        cmp("ibuf_flush", 4'h0, {3'h0, ibuf});
        if (blk === 1'b1)
          @(posedge clk_in) #1;
      end
      cmp("dispatch_block", 4'h0, {3'h0, blk});
    end
  endtask : issue

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(negedge clk_in)
  begin
    cycles++;
    if (!rst_in && rsp_out.valid === 1'b1)
    begin
      if (expq.size() == 0)
        cmp("rsp_valid", 4'h0, 4'h1);
      else
      begin
        e = expq.pop_front();
        cmp("align_exc", {3'h0, e[5]}, {3'h0, rsp_out.align_exc});
        cmp("store_go", {3'h0, e[4]}, {3'h0, rsp_out.store_go});
        cmp("cond_valid", {3'h0, e[6]}, {3'h0, rsp_out.cond_valid});
        if (e[7])
        begin
          cmp("cond_field", e[3:0], rsp_out.cond_field);
          cmp("cond_field_zero", e[3:0], cfz);
        end
      end
    end
    if (cycles == 10000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    rst_in = 1'b1;
    req_in = '0;
    snoop_kill_in = 1'b0;
    slow = 1'b0;
    rnd = 32'h217a_a2ee;
    resv_v = 1'b0;
    resv_tag = '0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    issue(2'd0, 1'b0, 32'h0000_1000);
    issue(2'd3, 1'b1, 32'h0000_1000);
    issue(2'd1, 1'b1, 32'h0000_101c);
    issue(2'd1, 1'b1, 32'h0000_1000);
    issue(2'd0, 1'b0, 32'h0000_1002);
    issue(2'd1, 1'b1, 32'h0000_1000);
    issue(2'd0, 1'b1, 32'h0000_1000);
    kill();
    issue(2'd1, 1'b1, 32'h0000_1004);
    issue(2'd0, 1'b0, 32'h0000_1008);
    issue(2'd1, 1'b0, 32'h0000_1008);
    issue(2'd2, 1'b1, 32'h0000_0000);
    repeat (300)
    begin
      rnd = lfsr(rnd);
      slow <= rnd[20];
      if (rnd[4:3] == 2'b00)
        kill();
      else
        issue(rnd[1:0] == 2'd3 ? 2'd0 : rnd[1:0], rnd[2] | rnd[21],
          {26'h000_0040, rnd[10:7], rnd[11] & rnd[12] ? rnd[14:13] : 2'b00});
    end
    @(posedge clk_in);
    req_in.valid <= 1'b0;
    repeat (5) @(posedge clk_in);
    cmp("rsp_pending", 4'h0, expq.size() == 0 ? 4'h0 : 4'h1);
    print_verdict();
  end
endmodule : rbu_top_tb

`default_nettype wire
